// file: inc/dcw_pkg.sv
// Package for the drive command word decoder: bit positions, states, timing.
// Assumes a single 100 MHz clock domain and a 16-bit command word.
package dcw_pkg;
    localparam int CMD_W = 16;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam int BIT_POWER_ON = 0;
    localparam int BIT_COAST_PERMIT = 1;
    localparam int BIT_QSTOP_PERMIT = 2;
    localparam int BIT_PULSE_EN = 3;
    localparam int BIT_RAMP_EN = 4;
    localparam int BIT_SETPOINT_EN = 6;
    localparam int BIT_FAULT_ACK = 7;
    localparam int BIT_SPEED_CTRL_EN = 8;
    localparam int BIT_BRAKE_OPEN = 9;
    localparam int BIT_REMOTE_MASTER = 10;
    localparam int BIT_TORQUE_MODE = 12;
    localparam int BIT_OVERSPEED = 15;
    localparam logic [15:0] RESERVED_MASK = 16'h6820;
    localparam int CLK_MHZ = 100;
    localparam int RAMP_US_DEFAULT = 1000;
    localparam int RAMP_CYC_DEFAULT = RAMP_US_DEFAULT * CLK_MHZ;
    localparam int HIST_DEPTH = 8;
    typedef enum logic [1:0] {
        DCW_OFF = 2'b00,
        DCW_RUN = 2'b01,
        DCW_RAMP = 2'b11
    } dcw_state_t;
endpackage

// file: core/dcw_hist_mem.sv
// Small history memory of accepted command words, registered read data.
// Assumes the caller supplies a write strobe and a read index per cycle.
`timescale 1ns/1ns
module dcw_hist_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Write side
    input wire logic wr_en_in,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Read side
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    // Checked at elaboration, so a bad setting never reaches silicon.
    if (DEPTH < 2) begin : g_bad_depth
        $error("dcw_hist_mem: DEPTH must be at least 2.");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0] filled_q;
    logic [WIDTH-1:0] rd_d;

    // Unwritten slots read as zero, so status never shows unknowns.
    always_comb begin
        rd_d = filled_q[rd_addr_in] ? mem_q[rd_addr_in] : '0;
    end

    always_ff @(posedge mclk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        if (!nrst_in) begin
            filled_q <= '0;
            rd_data_out <= '0;
        end else begin
            if (wr_en_in) begin
                filled_q[wr_addr_in] <= 1'b1;
            end
            rd_data_out <= rd_d;
        end
    end
endmodule // dcw_hist_mem

// file: core/dcw_decoder.sv
// Drive command word decoder: turns the cyclic first process-data word
// into power, stop, enable, acknowledge, brake and mode outputs.
// Assumes the command word and its strobe are synchronous to mclk_in.
//
// Behaviour
// [RULE1] Bit 0 powers up; clearing powers down normally.
// [RULE2] Bit 1 low blocks power-up, coasts immediately.
// [RULE3] Bit 2 low blocks power-up, ramps then off.
// [RULE4] Pulses inhibited unless bit 3 is set.
// [RULE5] Bit 4 passes ramped setpoint to controller.
// [RULE6] Bit 6 feeds setpoint into ramp generator.
// [RULE7] Bit 7 clears fault once cause is gone.
// [RULE8] Bit 8 enables the speed controller.
// [RULE9] Bit 9 requests brake open, internal brake control.
// [RULE10] Commands ignored unless bit 10 is set.
// [RULE11] Bit 12 selects torque over speed control.
// [RULE12] Controller sets bit 15 on hoist overspeed.
// [RULE13] Word arrives first in each synchronous telegram.
// [RULE14] Controller drives bits from two write paths.
// [RULE15] Reserved bits 5, 11, 13, 14 ignored.
// [RULE16] Coast-stop beats quick-stop, no ramp.
`timescale 1ns/1ns
module dcw_decoder
    import dcw_pkg::*;
#(
    parameter int RAMP_CYC = dcw_pkg::RAMP_CYC_DEFAULT,
    parameter bit HOIST_DRIVE = 1'b1,
    parameter bit BRAKE_INTERNAL = 1'b1
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Cyclic command word from the telegram
    input wire logic cmd_valid_in,
    input wire logic [dcw_pkg::CMD_W-1:0] command_word_in,
    // Fault source
    input wire logic fault_event_in,
    input wire logic fault_cause_in,
    // Drive controls
    output logic power_on_out,
    output logic pulses_enable_out,
    output logic ramping_down_out,
    output logic ramp_to_ctrl_out,
    output logic setpoint_to_ramp_out,
    output logic speed_ctrl_en_out,
    output logic brake_open_out,
    output logic torque_mode_out,
    output logic overspeed_out,
    // Status
    output logic fault_out,
    output logic [1:0] state_out,
    output logic [dcw_pkg::CMD_W-1:0] last_word_out
);
    import dcw_pkg::*;

    // Checked at elaboration, so a bad setting never reaches silicon.
    if (RAMP_CYC < 1) begin : g_bad_ramp
        $error("dcw_decoder: RAMP_CYC must be at least 1.");
    end
    // The history pointer wraps freely, so the depth must be a power of two.
    if (HIST_DEPTH < 2
        || (HIST_DEPTH & (HIST_DEPTH - 1)) != 0) begin : g_bad_hist
        $error("dcw_decoder: HIST_DEPTH must be a power of two.");
    end

    localparam int CW = $clog2(RAMP_CYC + 1);
    localparam int AW = $clog2(HIST_DEPTH);

    function automatic logic cbit(input logic [CMD_W-1:0] w, input int b);
        return w[b];
    endfunction

    dcw_state_t state_q, state_d;
    logic [CMD_W-1:0] word_q, word_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic fault_q, fault_d;
    logic [AW-1:0] wptr_q, wptr_d;
    logic pon_d, pen_d, rdn_d, r2c_d, s2r_d, sce_d, brk_d, trq_d, ovs_d;
    logic accept;
    logic [CMD_W-1:0] w;

    // Words without the remote-master flag are dropped whole.
    always_comb begin
        accept = cmd_valid_in && command_word_in[BIT_REMOTE_MASTER]; // RULE10
        word_d = accept ? (command_word_in & ~RESERVED_MASK) : word_q; // RULE15
        wptr_d = accept ? AW'(wptr_q + 1'b1) : wptr_q;
    end

    always_comb begin
        w = word_q;
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            DCW_OFF: begin
                if (cbit(w, BIT_POWER_ON) && cbit(w, BIT_COAST_PERMIT)
                    && cbit(w, BIT_QSTOP_PERMIT) && !fault_q) begin
                    state_d = DCW_RUN; // RULE1
                end
            end
            DCW_RUN: begin
                if (!cbit(w, BIT_COAST_PERMIT)) begin
                    state_d = DCW_OFF; // RULE2
                end else if (!cbit(w, BIT_QSTOP_PERMIT)
                             || !cbit(w, BIT_POWER_ON)) begin
                    state_d = DCW_RAMP; // RULE3
                    cnt_d = CW'(RAMP_CYC);
                end
            end
            DCW_RAMP: begin
                if (!cbit(w, BIT_COAST_PERMIT)) begin
                    state_d = DCW_OFF; // RULE16
                end else if (cnt_q <= CW'(1)) begin
                    state_d = DCW_OFF; // RULE3
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            // The unused code falls back to the safe off state.
            default: begin
                state_d = DCW_OFF;
                cnt_d = '0;
            end
        endcase
    end

    // Fault: a new event wins over an acknowledge in the same cycle.
    always_comb begin
        fault_d = fault_q;
        if (fault_event_in) begin
            fault_d = 1'b1;
        end else if (cbit(word_q, BIT_FAULT_ACK) && !fault_cause_in) begin
            fault_d = 1'b0; // RULE7
        end
    end

    // Pulses drop on coast-stop at once, without waiting for the state.
    always_comb begin
        pon_d = (state_d != DCW_OFF);
        pen_d = pon_d && cbit(word_q, BIT_PULSE_EN) // RULE4
                && cbit(word_q, BIT_COAST_PERMIT); // RULE2
        rdn_d = (state_d == DCW_RAMP);
        r2c_d = pon_d && cbit(word_q, BIT_RAMP_EN); // RULE5
        s2r_d = pon_d && !rdn_d && cbit(word_q, BIT_SETPOINT_EN); // RULE6
        sce_d = pon_d && cbit(word_q, BIT_SPEED_CTRL_EN); // RULE8
        brk_d = BRAKE_INTERNAL && cbit(word_q, BIT_BRAKE_OPEN); // RULE9
        trq_d = cbit(word_q, BIT_TORQUE_MODE); // RULE11
        ovs_d = HOIST_DRIVE && cbit(word_q, BIT_OVERSPEED); // RULE12
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            state_q <= DCW_OFF;
            word_q <= CMD_RESET;
            cnt_q <= '0;
            fault_q <= 1'b0;
            wptr_q <= '0;
            power_on_out <= 1'b0;
            pulses_enable_out <= 1'b0;
            ramping_down_out <= 1'b0;
            ramp_to_ctrl_out <= 1'b0;
            setpoint_to_ramp_out <= 1'b0;
            speed_ctrl_en_out <= 1'b0;
            brake_open_out <= 1'b0;
            torque_mode_out <= 1'b0;
            overspeed_out <= 1'b0;
            fault_out <= 1'b0;
            state_out <= 2'h0;
        end else begin
            state_q <= state_d;
            word_q <= word_d;
            cnt_q <= cnt_d;
            fault_q <= fault_d;
            wptr_q <= wptr_d;
            power_on_out <= pon_d;
            pulses_enable_out <= pen_d;
            ramping_down_out <= rdn_d;
            ramp_to_ctrl_out <= r2c_d;
            setpoint_to_ramp_out <= s2r_d;
            speed_ctrl_en_out <= sce_d;
            brake_open_out <= brk_d;
            torque_mode_out <= trq_d;
            overspeed_out <= ovs_d;
            fault_out <= fault_d;
            state_out <= state_d;
        end
    end

    // Accepted words are logged; the newest is read back as status.
    dcw_hist_mem #(
        .WIDTH(CMD_W),
        .DEPTH(HIST_DEPTH)
    ) u_hist (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .wr_en_in(accept),
        .wr_addr_in(wptr_q),
        .wr_data_in(word_d),
        .rd_addr_in(AW'(wptr_q - 1'b1)),
        .rd_data_out(last_word_out)
    );
endmodule // dcw_decoder

// file: test/dcw_ctrl_model.sv
// Motion controller model: sends one cyclic command word per call.
// Assumes the caller supplies the drive clock.
`timescale 1ns/1ns
module dcw_ctrl_model (
    // Clock
    input wire logic clk_in,
    // Telegram word
    output logic valid_out,
    output logic [15:0] word_out
);
    initial begin
        valid_out = 1'b0;
        word_out = 16'h0000;
    end
    // Raw sends keep reserved bits, so that a scenario can misbehave.
    task automatic send(input logic [15:0] w, input bit raw);
        @(negedge clk_in);
        valid_out <= 1'b1;
        word_out <= raw ? w : w & ~dcw_pkg::RESERVED_MASK;
        @(negedge clk_in);
        valid_out <= 1'b0;
        word_out <= ~w;
    endtask
endmodule // dcw_ctrl_model

// file: test/dcw_decoder_monitor.sv
// Checker for the command word decoder, bound to its ports.
// Assumes outputs follow an accepted word two edges later.
`timescale 1ns/1ns
module dcw_decoder_monitor
    import dcw_pkg::*;
(
    // Inputs
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic cmd_valid_in,
    input wire logic [15:0] command_word_in,
    input wire logic fault_event_in,
    input wire logic fault_cause_in,
    // Outputs
    input wire logic power_on_out,
    input wire logic pulses_enable_out,
    input wire logic ramping_down_out,
    input wire logic setpoint_to_ramp_out,
    input wire logic brake_open_out,
    input wire logic torque_mode_out,
    input wire logic fault_out,
    input wire logic [1:0] state_out
);
    wire [15:0] w = command_word_in;
    wire acc = cmd_valid_in & w[10];
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    property p_trq; acc |-> ##2 torque_mode_out == $past(w[12], 2);
    endproperty
    a_trq: assert property (p_trq) else $error("bad torque");
    property p_brk; acc |-> ##2 brake_open_out == $past(w[9], 2);
    endproperty
    a_brk: assert property (p_brk) else $error("bad brake");
    property p_ign; !acc |-> ##2 $stable(torque_mode_out); endproperty
    a_ign: assert property (p_ign) else $error("word not ignored");
    property p_pls; acc && !w[3] |-> ##2 !pulses_enable_out; endproperty
    a_pls: assert property (p_pls) else $error("pulses on");
    property p_cst; acc && !w[1] |-> ##2 !pulses_enable_out && !state_out;
    endproperty
    a_cst: assert property (p_cst) else $error("no coast");
    property p_pup; !$past(acc) && state_out == DCW_OFF && !fault_out &&
        !$past(fault_event_in) && !fault_event_in && acc && w[2:0] == 3'h7
        ##1 !fault_event_in |-> ##1 power_on_out; endproperty
    a_pup: assert property (p_pup) else $error("no power up");
    property p_rmp; !$past(acc) && state_out == DCW_RUN && acc && w[1] &&
        !w[2] && !fault_event_in |-> ##2 state_out == DCW_RAMP &&
        ramping_down_out && !setpoint_to_ramp_out; endproperty
    a_rmp: assert property (p_rmp) else $error("no ramp");
    property p_flt; fault_out && fault_cause_in && $past(fault_cause_in)
        |=> fault_out; endproperty
    a_flt: assert property (p_flt) else $error("fault cleared");
    c_up: cover property (power_on_out && pulses_enable_out);
    c_rmp: cover property (ramping_down_out);
    c_flt: cover property (fault_out && fault_cause_in);
endmodule // dcw_decoder_monitor
bind dcw_decoder dcw_decoder_monitor mon (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .cmd_valid_in(cmd_valid_in),
    .command_word_in(command_word_in),
    .fault_event_in(fault_event_in),
    .fault_cause_in(fault_cause_in),
    .power_on_out(power_on_out),
    .pulses_enable_out(pulses_enable_out),
    .ramping_down_out(ramping_down_out),
    .setpoint_to_ramp_out(setpoint_to_ramp_out),
    .brake_open_out(brake_open_out),
    .torque_mode_out(torque_mode_out),
    .fault_out(fault_out),
    .state_out(state_out)
);

// file: test/testbench.sv
// Testbench for the command word decoder with a controller model.
// Assumes a short ramp parameter so that stops finish quickly.
`timescale 1ns/1ns
module testbench;
    import dcw_pkg::*;
    logic mclk_in = 1'b0, nrst_in = 1'b0, fev = 1'b0, fca = 1'b0, cv;
    logic [15:0] cw, lw;
    logic po, pe, rd, tq, bo, os, ft, rc, sr, se;
    logic [1:0] st;
    int bad_count = 0, tests_run = 0;
    dcw_ctrl_model ctl (.clk_in(mclk_in), .valid_out(cv), .word_out(cw));
    dcw_decoder #(.RAMP_CYC(5)) uut (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .cmd_valid_in(cv), .command_word_in(cw), .fault_event_in(fev),
        .fault_cause_in(fca), .power_on_out(po), .pulses_enable_out(pe),
        .ramping_down_out(rd), .ramp_to_ctrl_out(rc),
        .setpoint_to_ramp_out(sr), .speed_ctrl_en_out(se),
        .brake_open_out(bo), .torque_mode_out(tq),
        .overspeed_out(os), .fault_out(ft), .state_out(st),
        .last_word_out(lw));
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    function automatic logic [15:0] fx(input logic [15:0] w);
        return {13'h0000, w[15], w[12], w[9]};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, s);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic go(input logic [15:0] w, input bit raw, input int n);
        ctl.send(w, raw);
        repeat (n) @(negedge mclk_in);
    endtask
    initial begin
        logic [15:0] r;
        void'($urandom(32'hB6C2882A));
        repeat (3) @(negedge mclk_in);
        nrst_in = 1'b1;
        go(16'h055D, 0, 3);
        chk("refuse", 16'h0000, {12'h000, po, pe, st});
        go(16'h055F, 0, 3);
        chk("up", 16'h000D, {12'h000, po, pe, st});
        chk("en on", 16'h0007, {13'h0000, rc, sr, se});
        go(16'h040F, 0, 3);
        chk("en off", 16'h0000, {13'h0000, rc, sr, se});
        go(16'h1000, 0, 3);
        chk("ignored", 16'h000D, {11'h000, tq, po, pe, st});
        go(16'h0557, 0, 3);
        chk("pulses", 16'h0009, {12'h000, po, pe, st});
        go(16'h755F, 1, 3);
        chk("reserved", 16'h155F, lw);
        go(16'h055B, 0, 1);
        chk("ramp", 16'h0007, {13'h0000, rd, st});
        chk("ramp en", 16'h0005, {13'h0000, rc, sr, se});
        repeat (8) @(negedge mclk_in);
        chk("ramp end", 16'h0000, {13'h0000, rd, st});
        go(16'h055F, 0, 3);
        go(16'h0559, 0, 1);
        chk("coast", 16'h0000, {12'h000, po, pe, st});
        fev = 1'b1;
        fca = 1'b1;
        @(negedge mclk_in);
        fev = 1'b0;
        go(16'h0480, 0, 3);
        chk("fault held", 16'h0001, {15'h0000, ft});
        fca = 1'b0;
        go(16'h0480, 0, 3);
        chk("fault clear", 16'h0000, {15'h0000, ft});
        repeat (40) begin
            r = 16'($urandom()) | 16'h0400;
            go(r, 0, 3);
            chk("fields", fx(r), {13'h0000, os, tq, bo});
        end
        stop_test();
    end
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
endmodule // testbench
